// ---- dv/iavs_cpu_model.sv ----
// host cpu model: issues acknowledge pulses and captures the bytes offered
module iavs_cpu_model (
  input  wire logic       clk_i,
  output logic            irq_ack_n_o,
  input  wire logic [7:0] data_i,
  input  wire logic       data_oe_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] byte_q [3];
  logic       oe_q   [3];
  initial irq_ack_n_o = 1'b1;
  // lo sets the low phase; high phase of 5 keeps pulses well apart
  task automatic ack_seq(input int n, input int lo);
    for (int i = 0; i < n; i++) begin
      irq_ack_n_o <= 1'b0;
      repeat (lo) @(posedge clk_i);
      // an undriven bus reads back inverted, so a missing enable cannot pass
      byte_q[i] = data_oe_i ? data_i : ~data_i;
      oe_q[i]   = data_oe_i;
      irq_ack_n_o <= 1'b1;
      repeat (5) @(posedge clk_i);
    end
  endtask
endmodule

// ---- dv/testbench.sv ----
// self-checking bench for the acknowledge vector sequencer
module testbench;
  import iavs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] VEC = 16'h12e0;
  logic        clk_i, rst_i, irq_ack_n, irq_int, data_oe, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0]  irq_req, data;
  logic [4:0]  wb_adr;
  logic [31:0] wb_dat, wb_q, q;
  int          mismatches, n_compared;
  iavs_sequencer iavs_sequencer_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .irq_req_in_i(irq_req),
    .irq_ack_n_i(irq_ack_n), .irq_int_o(irq_int), .data_o(data), .data_oe_o(data_oe), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_q), .wb_ack_o(wb_ack));
  iavs_cpu_model iavs_cpu_model_i (.clk_i(clk_i), .irq_ack_n_o(irq_ack_n), .data_i(data), .data_oe_i(data_oe));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ********************************************
  // helpers
  // ********************************************
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wb(input logic [4:0] a, input logic we, input logic [31:0] d);
    int k;
    k = 0;
    wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we; wb_adr <= a; wb_dat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack !== 1'b1 && k < 50);
    if (k >= 50) begin
      mismatches++;
      complete_run();
    end
    q = wb_q;
    wb_cyc <= 1'b0; wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wait_int();
    int k;
    for (k = 0; k < 40 && irq_int !== 1'b1; k++) @(posedge clk_i);
    check("irq_int_o raised", 32'(irq_int), 32'h1);
    if (irq_int !== 1'b1) complete_run();
  endtask
  function automatic logic [7:0] lo8(input logic [2:0] l);
    return {VEC[7:6], l, 3'h0};
  endfunction
  // one full acknowledge sequence; b1 low byte or pointer, high byte checked against VEC[15:8] only when n is 3
  task automatic seq(input logic [7:0] req, input bit drop, input int n, input logic [7:0] b1,
                     input logic [7:0] in_service_reg);
    irq_req <= req;
    wait_int();
    if (drop) irq_req <= 8'h00;
    repeat (5) @(posedge clk_i);
    fork
      iavs_cpu_model_i.ack_seq(n, 6);
      begin
        // held past the first falling edge, then released within the first pulse so nothing re-triggers at the end
        repeat (4) @(posedge clk_i);
        irq_req <= 8'h00;
      end
    join
    repeat (2) @(posedge clk_i);
    check("irq_int_o low", 32'(irq_int), 32'h0);
    if (n == 3) begin
      check("call byte", 32'(iavs_cpu_model_i.byte_q[0]), 32'(CALL_OP));
      check("high byte", 32'(iavs_cpu_model_i.byte_q[2]), 32'(VEC[15:8]));
    end else begin
      check("first oe", 32'(iavs_cpu_model_i.oe_q[0]), 32'h0);
    end
    check("vector byte", 32'(iavs_cpu_model_i.byte_q[1]), 32'(b1));
    wb(OFF_STAT, 1'b0, 32'h0);
    check("in service", 32'(q[15:8]), 32'(in_service_reg));
    irq_req <= 8'h00;
    repeat (4) @(posedge clk_i);
    $display("sequence test done");
  endtask
  // ********************************************
  // main sequence
  // ********************************************
  initial begin
    rst_i = 1'b1; irq_req = 8'h00; wb_cyc = 1'b0; wb_stb = 1'b0; wb_we = 1'b0; wb_adr = 5'h00;
    wb_dat = 32'h0; mismatches = 0; n_compared = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(OFF_CTRL, 1'b0, 32'h0);
    check("ctrl reset", q, CTRL_RST);
    wb(OFF_MASK, 1'b0, 32'h0);
    check("mask reset", q, 32'(MASK_RST));
    wb(5'h1c, 1'b0, 32'h0);
    check("unmapped read", q, 32'h0);
    wb(OFF_VEC, 1'b1, 32'(VEC));
    wb(OFF_TYPE, 1'b1, 32'ha8);
    $display("register test done");
    seq(8'h08, 1'b0, 3, lo8(3'h3), 8'h08);
    wb(OFF_EOI, 1'b1, 32'h08);
    wb(OFF_STAT, 1'b0, 32'h0);
    check("in service after eoi", 32'(q[15:8]), 32'h0);
    wb(OFF_CTRL, 1'b1, 32'h6);
    seq(8'h20, 1'b0, 3, {VEC[7:5], 3'h5, 2'h0}, 8'h00);
    wb(OFF_CTRL, 1'b1, 32'h7);
    seq(8'h40, 1'b0, 2, {5'b10101, 3'h6}, 8'h00);
    wb(OFF_CTRL, 1'b1, 32'h0);
    seq(8'h04, 1'b1, 3, lo8(3'h7), 8'h00);
    wb(OFF_MASK, 1'b1, 32'h02);
    irq_req <= 8'h02;
    repeat (10) @(posedge clk_i);
    check("masked no int", 32'(irq_int), 32'h0);
    wb(OFF_STAT, 1'b0, 32'h0);
    check("pending set", 32'(q[1]), 32'h1);
    seq(8'h42, 1'b0, 3, lo8(3'h6), 8'h40);
    complete_run();
  end
endmodule

// ---- logic/iavs_pkg.sv ----
// package: offsets, field positions, reset values and types of the ack vector sequencer
package iavs_pkg;

  // ********************************************
  // register map (byte addresses)
  // ********************************************
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_VEC  = 5'h04;
  localparam logic [4:0] OFF_TYPE = 5'h08;
  localparam logic [4:0] OFF_MASK = 5'h0c;
  localparam logic [4:0] OFF_EOI  = 5'h10;
  localparam logic [4:0] OFF_STAT = 5'h14;

  // ********************************************
  // control fields and reset values
  // ********************************************
  localparam int          CTRL_TWO_PULSE = 0;
  localparam int          CTRL_AUTO_END_OF_IRQ      = 1;
  localparam int          CTRL_ADI4      = 2;
  localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
  localparam logic [15:0] VEC_RST        = 16'h0000;
  localparam logic [4:0]  TYPE_RST       = 5'h00;
  localparam logic [7:0]  MASK_RST       = 8'h00;

  // ********************************************
  // sequence constants
  // ********************************************
  localparam logic [7:0] CALL_OP     = 8'hcd;
  localparam logic [1:0] PULSES_CALL = 2'h3;
  localparam logic [1:0] PULSES_PTR  = 2'h2;
  localparam logic [2:0] NOISE_LVL   = 3'h7;
  localparam logic [3:0] NO_ISR      = 4'h8;

  typedef struct packed {
    logic        two_pulse;
    logic        auto_end_of_irq;
    logic        call_interval_sel;
    logic [15:0] vec;
    logic [4:0]  pointer_type_bits;
    logic [7:0]  mask;
  } iavs_cfg_s;

  typedef enum logic [1:0] {
    S_IDLE,
    S_LOW,
    S_HIGH
  } iavs_state_e;

endpackage

// ---- logic/iavs_sequencer.sv ----
// interrupt acknowledge vector sequencer with wishbone register slave
// ********************************************
// Functional notes
// - high request input sets its pending bit
// - raise interrupt only for eligible unmasked request
// - three-byte mode: call opcode on pulse one
// - three-byte mode: low byte, then high byte
// - third pulse sets in-service, clears pending
// - auto eoi clears in-service at third trailing
// - without auto eoi, in-service waits for eoi
// - interval four: A7-A5, level, two zeros
// - interval eight: A7-A6, level, three zeros
// - high byte carries A15 to A8
// - two-pulse mode: bus undriven on pulse one
// - two-pulse mode: pointer on pulse two
// - pointer is type bits T7-T3, level
// - pointer ignores address bits and interval
// - auto eoi clears in-service at second trailing
// - dropped request yields level seven, no in-service
// - interrupt output falls when sequence ends
// ********************************************
module iavs_sequencer (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [7:0]  irq_req_in_i,
  input  wire logic        irq_ack_n_i,
  output logic             irq_int_o,
  output logic [7:0]       data_o,
  output logic             data_oe_o,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);
  import iavs_pkg::*;

  // ********************************************
  // pin synchronisers
  // ********************************************
  logic [7:0] req_s1_q, req_s2_q;
  logic       ack_s1_q, ack_s2_q, ack_s3_q;
  logic       fall, rise;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_s1_q <= 8'h00;
      req_s2_q <= 8'h00;
      ack_s1_q <= 1'b1;
      ack_s2_q <= 1'b1;
      ack_s3_q <= 1'b1;
    end else if (ce_i) begin
      req_s1_q <= irq_req_in_i;
      req_s2_q <= req_s1_q;
      ack_s1_q <= irq_ack_n_i;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
    end
  end

  // edges seen only after the second stage; a pulse sampled at no clock edge is lost
  assign fall = ack_s3_q & ~ack_s2_q;
  assign rise = ~ack_s3_q & ack_s2_q;

  // ********************************************
  // wishbone slave
  // ********************************************
  iavs_cfg_s   cfg_q, cfg_d;
  logic        ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [7:0]  eoi_clr;
  logic [31:0] wmask, img;
  logic [7:0]  pending_q, pending_d;
  logic [7:0]  in_service_q, in_service_d;
  logic [2:0]  lvl_q, lvl_d;
  logic        valid_q, valid_d;
  logic [1:0]  cnt_q, cnt_d;
  logic        int_q, int_d;

  always_comb begin
    cfg_d   = cfg_q;
    eoi_clr = 8'h00;
    ack_d   = wb_cyc_i & wb_stb_i & ~ack_q;
    rdat_d  = rdat_q;
    wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    img     = 32'h0000_0000;
    case (wb_adr_i)
      OFF_CTRL: begin
        img = {29'h0, cfg_q.call_interval_sel, cfg_q.auto_end_of_irq, cfg_q.two_pulse};
      end
      OFF_VEC:  img = {16'h0, cfg_q.vec};
      OFF_TYPE: img = {24'h0, cfg_q.pointer_type_bits, 3'h0};
      OFF_MASK: img = {24'h0, cfg_q.mask};
      OFF_STAT: img = {9'h0, int_q, valid_q, lvl_q, cnt_q, in_service_q, pending_q};
      default:  img = 32'h0000_0000;
    endcase
    if (ack_d) begin
      rdat_d = wb_we_i ? 32'h0000_0000 : img;
    end
    // a write lands at the edge where the master samples ack, its request still standing
    if (ack_q && wb_cyc_i && wb_stb_i && wb_we_i) begin
      img = (img & ~wmask) | (wb_dat_i & wmask);
      case (wb_adr_i)
        OFF_CTRL: begin
          cfg_d.two_pulse         = img[CTRL_TWO_PULSE];
          cfg_d.auto_end_of_irq   = img[CTRL_AUTO_END_OF_IRQ];
          cfg_d.call_interval_sel = img[CTRL_ADI4];
        end
        OFF_VEC:  cfg_d.vec = img[15:0];
        OFF_TYPE: cfg_d.pointer_type_bits = img[7:3];
        OFF_MASK: cfg_d.mask = img[7:0];
        OFF_EOI:  eoi_clr = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00; // end_of_irq_cmd
        default:  eoi_clr = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q  <= {CTRL_RST[CTRL_TWO_PULSE], CTRL_RST[CTRL_AUTO_END_OF_IRQ], CTRL_RST[CTRL_ADI4], VEC_RST, TYPE_RST, MASK_RST};
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else if (ce_i) begin
      cfg_q  <= cfg_d;
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ********************************************
  // priority resolver: level 0 highest, fixed
  // ********************************************
  logic [7:0] cand;
  logic       has_cand, eligible;
  logic [2:0] cand_lvl;
  logic [3:0] isr_top;

  always_comb begin
    cand     = pending_q & ~cfg_q.mask;
    has_cand = 1'b0;
    cand_lvl = 3'h0;
    isr_top  = NO_ISR;
    for (int i = 7; i >= 0; i--) begin
      if (cand[i]) begin
        has_cand = 1'b1;
        cand_lvl = 3'(i);
      end
      if (in_service_q[i]) begin
        isr_top = 4'(i);
      end
    end
    // a level in service blocks itself and all lower levels
    eligible = has_cand && ({1'b0, cand_lvl} < isr_top);
  end

  // ********************************************
  // acknowledge sequence
  // ********************************************
  iavs_state_e st_q, st_d;
  logic [7:0]  dat_q, dat_d;
  logic        oe_q, oe_d;
  logic [1:0]  last_n, nxt_n;
  logic [2:0]  nxt_lvl;
  logic [7:0]  lvl_bit;

  always_comb begin
    st_d         = st_q;
    cnt_d        = cnt_q;
    lvl_d        = lvl_q;
    valid_d      = valid_q;
    int_d        = int_q;
    dat_d        = dat_q;
    oe_d         = oe_q;
    last_n       = cfg_q.two_pulse ? PULSES_PTR : PULSES_CALL;
    nxt_n        = cnt_q + 2'h1;
    nxt_lvl      = lvl_q;
    lvl_bit      = 8'h01 << lvl_q;
    in_service_d = in_service_q & ~eoi_clr;
    // before the first pulse the pending bits follow the pins, so a dropped request vanishes
    pending_d    = (st_q == S_IDLE) ? req_s2_q : pending_q;
    case (st_q)
      S_IDLE: begin
        int_d = int_q | eligible;
        if (fall) begin
          nxt_lvl = eligible ? cand_lvl : NOISE_LVL;
          lvl_d   = nxt_lvl;
          valid_d = eligible;
          cnt_d   = 2'h1;
          st_d    = S_LOW;
        end
      end
      S_HIGH: begin
        if (fall) begin
          cnt_d = nxt_n;
          st_d  = S_LOW;
          if (nxt_n == last_n && valid_q) begin
            in_service_d = in_service_d | lvl_bit;
            pending_d    = pending_q & ~lvl_bit;
          end
        end
      end
      S_LOW: begin
        if (rise) begin
          oe_d = 1'b0;
          st_d = S_HIGH;
          if (cnt_q == last_n) begin
            // a noise sequence set no in-service bit, so it must clear none either
            if (cfg_q.auto_end_of_irq && valid_q) begin
              in_service_d = in_service_d & ~lvl_bit;
            end
            int_d = 1'b0;
            cnt_d = 2'h0;
            st_d  = S_IDLE;
          end
        end
      end
      default: st_d = S_IDLE;
    endcase
    pending_d = pending_d | req_s2_q;
    if (fall && st_q != S_LOW) begin
      oe_d = 1'b1;
      case (cfg_q.two_pulse ? {1'b1, cnt_d} : {1'b0, cnt_d})
        3'h1: dat_d = CALL_OP;
        3'h2: begin
          if (cfg_q.call_interval_sel) begin
            dat_d = {cfg_q.vec[7:5], nxt_lvl, 2'h0};
          end else begin
            dat_d = {cfg_q.vec[7:6], nxt_lvl, 3'h0};
          end
        end
        3'h3: dat_d = cfg_q.vec[15:8];
        3'h6: dat_d = {cfg_q.pointer_type_bits, nxt_lvl};
        default: oe_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q         <= S_IDLE;
      cnt_q        <= 2'h0;
      lvl_q        <= 3'h0;
      valid_q      <= 1'b0;
      int_q        <= 1'b0;
      dat_q        <= 8'h00;
      oe_q         <= 1'b0;
      pending_q    <= 8'h00;
      in_service_q <= 8'h00;
    end else if (ce_i) begin
      st_q         <= st_d;
      cnt_q        <= cnt_d;
      lvl_q        <= lvl_d;
      valid_q      <= valid_d;
      int_q        <= int_d;
      dat_q        <= dat_d;
      oe_q         <= oe_d;
      pending_q    <= pending_d;
      in_service_q <= in_service_d;
    end
  end

  assign irq_int_o = int_q;
  assign data_o    = dat_q;
  assign data_oe_o = oe_q;

  // ********************************************
  // assertions
  // ********************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  call_byte_a: assert property ((oe_q && cnt_q == 2'h1) |-> (!cfg_q.two_pulse && dat_q == CALL_OP))
    else $error("call opcode wrong on first pulse");
  low_byte_a: assert property ((oe_q && cnt_q == 2'h2 && !cfg_q.two_pulse) |->
      dat_q == (cfg_q.call_interval_sel ? {cfg_q.vec[7:5], lvl_q, 2'h0} : {cfg_q.vec[7:6], lvl_q, 3'h0}))
    else $error("low vector byte wrong");
  high_byte_a: assert property ((oe_q && cnt_q == 2'h3) |-> dat_q == cfg_q.vec[15:8])
    else $error("high vector byte wrong");
  pointer_a: assert property ((oe_q && cnt_q == 2'h2 && cfg_q.two_pulse) |->
      dat_q == {cfg_q.pointer_type_bits, lvl_q})
    else $error("pointer byte wrong");
  first_hiz_a: assert property ((st_q == S_LOW && cnt_q == 2'h1 && cfg_q.two_pulse) |-> !oe_q)
    else $error("bus driven on first pulse in two-pulse mode");
  int_drop_a: assert property ((st_q == S_LOW && rise && cnt_q == last_n) |=> (!int_q && st_q == S_IDLE))
    else $error("interrupt output not dropped at sequence end");
  isr_set_a: assert property ((st_q == S_HIGH && fall && nxt_n == last_n && valid_q) |=>
      (in_service_q[lvl_q] && oe_q))
    else $error("in-service bit not set on last pulse");
  noise_lvl_a: assert property ((st_q == S_IDLE && fall && !eligible) |=>
      (lvl_q == NOISE_LVL && !valid_q))
    else $error("dropped request not handled as level seven");
  noise_isr_a: assert property ((st_q == S_HIGH && fall && !valid_q) |=>
      ((in_service_q & ~$past(in_service_q)) == 8'h00))
    else $error("in-service bit set for dropped request");
  auto_end_of_irq_clr_a: assert property ((st_q == S_LOW && rise && cnt_q == last_n && valid_q &&
      cfg_q.auto_end_of_irq) |=> !in_service_q[lvl_q])
    else $error("auto eoi did not clear in-service bit");
  keep_isr_a: assert property (!$past(cfg_q.auto_end_of_irq) |->
      ((~in_service_q & $past(in_service_q) & ~$past(eoi_clr)) == 8'h00))
    else $error("in-service bit cleared without eoi");
  int_cause_a: assert property ($rose(int_q) |-> $past(eligible))
    else $error("interrupt raised without eligible request");
  level_hold_a: assert property ((st_q != S_IDLE) |=> $stable(lvl_q) || $past(st_q) == S_IDLE)
    else $error("level changed during sequence");
  pend_set_a: assert property ((req_s2_q != 8'h00) |=> ((pending_q & $past(req_s2_q)) == $past(req_s2_q)))
    else $error("pending bit not set by request");
  wb_ack_a: assert property (ack_q |=> !ack_q)
    else $error("bus ack held for more than one cycle");

endmodule
